// ---- common/nic_pkg.sv ----
// Purpose: constants shared by the interrupt controller files
// Assumes: 32-bit AXI4-Lite data, byte addresses, one word per register
// Notes:   flag bit positions, register offsets and reset values
`default_nettype none

package nic_pkg;

	localparam int NIC_ADDR_W = 8;
	localparam int NIC_DATA_W = 32;
	localparam int NIC_FLAG_W = 7;

	// register byte offsets
	localparam logic [7:0] NIC_OFS_FLAGS_PRI  = 8'h00;
	localparam logic [7:0] NIC_OFS_FLAGS_SEC  = 8'h04;
	localparam logic [7:0] NIC_OFS_EN_PRI     = 8'h08;
	localparam logic [7:0] NIC_OFS_EN_SEC     = 8'h0c;
	localparam logic [7:0] NIC_OFS_STATUS_ONE = 8'h10;
	localparam logic [7:0] NIC_OFS_PIN_CTRL   = 8'h14;
	localparam logic [7:0] NIC_OFS_EVT_STAT   = 8'h18;
	localparam logic [7:0] NIC_OFS_EVT_MASK   = 8'h1c;

	// flag register write selector and primary flag positions
	localparam int NIC_SETCLR_BIT   = 7;
	localparam int NIC_P_TX_DONE    = 0;
	localparam int NIC_P_RX_END     = 1;
	localparam int NIC_P_CMD_IDLE   = 2;
	localparam int NIC_P_FIFO_HI    = 3;
	localparam int NIC_P_FIFO_LO    = 4;
	localparam int NIC_P_RX_ERR     = 5;
	localparam int NIC_P_RX_SOF     = 6;

	// secondary flag positions
	localparam int NIC_S_TIMER0     = 0;
	localparam int NIC_S_TIMERS     = 4;
	localparam int NIC_S_CARD       = 4;
	localparam int NIC_S_ANY_SOURCE = 6;

	// status one, pin control and bus event fields
	localparam int NIC_ST_IRQ       = 0;
	localparam int NIC_PC_ENABLE    = 0;
	localparam int NIC_PC_ACT_LOW   = 1;
	localparam int NIC_EV_BAD_WR    = 0;
	localparam int NIC_EV_BAD_RD    = 1;
	localparam int NIC_EV_PENDING   = 2;
	localparam int NIC_EV_W         = 3;

	// reset values
	localparam logic [6:0] NIC_FLAGS_RST    = 7'h00;
	localparam logic [7:0] NIC_EN_RST       = 8'h00;
	localparam logic [1:0] NIC_PIN_CTRL_RST = 2'h0;
	localparam logic [2:0] NIC_EVT_MASK_RST = 3'h0;

	localparam logic [1:0] NIC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] NIC_RESP_SLVERR = 2'h2;

endpackage : nic_pkg

`default_nettype wire

// ---- hw/nic_flag_bank.sv ----
// Purpose: one seven-bit interrupt flag register with set/clear writes
// Assumes: write pulse lasts one cycle, hardware set lines are levels
// Notes:   hardware set wins over a software clear in the same cycle
`default_nettype none

module nic_flag_bank
	import nic_pkg::*;
#(
	parameter int W = NIC_FLAG_W
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         wr_en,
	input  wire logic [7:0]   wr_data,
	input  wire logic [W-1:0] hw_set,
	output logic      [W-1:0] flags
);

	typedef struct packed {
		logic [W-1:0] flags;
	} nic_bank_s;

	nic_bank_s s_q;
	nic_bank_s s_d;

	always_comb begin
		s_d = s_q;
		if (wr_en) begin
			if (wr_data[NIC_SETCLR_BIT]) begin // R2
				s_d.flags = s_q.flags | wr_data[W-1:0]; // R7
			end else begin
				s_d.flags = s_q.flags & ~wr_data[W-1:0]; // R7
			end
		end
		s_d.flags = s_d.flags | hw_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q.flags <= W'(NIC_FLAGS_RST);
		end else begin
			s_q <= s_d;
		end
	end

	assign flags = s_q.flags;

endmodule // nic_flag_bank

`default_nettype wire

// ---- hw/nic_irq_ctrl.sv ----
// Purpose: interrupt controller of a contactless reader frontend
// Assumes: event inputs synchronous to aclk, AXI4-Lite register access
// Notes:   flag registers read bit 7 as zero
//
// What this block does
// R1 - two 7-bit flag registers, each with its own 8-bit enable register
// R2 - bit 7 of a flag write chooses set or clear of bits 0 to 6
// R3 - software can raise any flag and clear any pending flag by writing
// R4 - each flag reaches the interrupt only if its enable bit is one
// R5 - pending event sets status irq bit; pin follows only when activated
// R6 - timer underflows set the four timer flags of the second register
// R7 - bit 7 high sets written ones, low clears them, zeros keep
// R8 - global flag set while any other flag is set and enabled
// R9 - transmit done set when transmitter enters end-of-frame pattern
// R10 - idle flag set when a command completes and goes idle
// R11 - error flag set while any receive error bit is set
//
// The address map and the AXI4-Lite register port were decided locally.
`default_nettype none

module nic_irq_ctrl
	import nic_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,

	input  wire logic [NIC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [NIC_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [NIC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [NIC_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,

	input  wire logic                  tx_eof_pattern,
	input  wire logic                  rx_end,
	input  wire logic                  cmd_busy,
	input  wire logic                  fifo_hi_alert,
	input  wire logic                  fifo_lo_alert,
	input  wire logic [7:0]            uart_error,
	input  wire logic                  rx_sof,
	input  wire logic [3:0]            timer_underflow,
	input  wire logic                  card_detected,

	output logic                       irq_req
);

	typedef struct packed {
		logic                  aw_have;
		logic [NIC_ADDR_W-1:0] aw_addr;
		logic                  w_have;
		logic [NIC_DATA_W-1:0] w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [NIC_DATA_W-1:0] rdata;
		logic [1:0]            rresp;
		logic [7:0]            en_pri;
		logic [7:0]            en_sec;
		logic [1:0]            pin_ctrl;
		logic [NIC_EV_W-1:0]   evt;
		logic [NIC_EV_W-1:0]   evt_mask;
		logic                  tx_eof_q;
		logic                  cmd_busy_q;
		logic                  pending_q;
		logic                  irq;
	} nic_main_s;

	nic_main_s s_q;
	nic_main_s s_d;

	logic [NIC_FLAG_W-1:0] flags_pri;
	logic [NIC_FLAG_W-1:0] flags_sec;
	logic [NIC_FLAG_W-1:0] set_pri;
	logic [NIC_FLAG_W-1:0] set_sec;
	logic                  commit;
	logic                  wr_lane0;
	logic                  wr_flags_pri;
	logic                  wr_flags_sec;
	logic                  rd_take;
	logic                  any_enabled;
	logic                  pending;
	logic [NIC_EV_W-1:0]   evt_new;
	logic [NIC_EV_W-1:0]   evt_clr;
	logic [7:0]            rd_byte;
	logic                  rd_ok;
	logic                  wr_ok;

	// a write is carried out once address and data are both held
	assign commit   = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
	assign wr_lane0 = commit & s_q.w_strb[0];
	assign rd_take  = s_axi_arvalid & ~s_q.rvalid;

	assign wr_flags_pri = wr_lane0 &
		(s_q.aw_addr == NIC_OFS_FLAGS_PRI); // R3
	assign wr_flags_sec = wr_lane0 &
		(s_q.aw_addr == NIC_OFS_FLAGS_SEC); // R3

	// hardware event sources of the primary register
	always_comb begin
		set_pri = '0;
		set_pri[NIC_P_TX_DONE]  = tx_eof_pattern & ~s_q.tx_eof_q; // R9
		set_pri[NIC_P_RX_END]   = rx_end;
		set_pri[NIC_P_CMD_IDLE] = s_q.cmd_busy_q & ~cmd_busy; // R10
		set_pri[NIC_P_FIFO_HI]  = fifo_hi_alert;
		set_pri[NIC_P_FIFO_LO]  = fifo_lo_alert;
		set_pri[NIC_P_RX_ERR]   = |uart_error; // R11
		set_pri[NIC_P_RX_SOF]   = rx_sof;
	end

	// enabled sources, global flag excluded from its own term
	assign any_enabled =
		|(flags_pri & s_q.en_pri[NIC_FLAG_W-1:0]) | // R4
		|(flags_sec[NIC_S_ANY_SOURCE-1:0] &
		  s_q.en_sec[NIC_S_ANY_SOURCE-1:0]); // R4

	// hardware event sources of the secondary register
	always_comb begin
		set_sec = '0;
		set_sec[NIC_S_TIMER0 +: NIC_S_TIMERS] = timer_underflow; // R6
		set_sec[NIC_S_CARD] = card_detected;
		set_sec[NIC_S_ANY_SOURCE] = any_enabled; // R8
	end

	nic_flag_bank #(
		.W (NIC_FLAG_W)
	) u_flags_pri (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_flags_pri),
		.wr_data (s_q.w_data[7:0]),
		.hw_set  (set_pri),
		.flags   (flags_pri)
	); // R1

	nic_flag_bank #(
		.W (NIC_FLAG_W)
	) u_flags_sec (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_flags_sec),
		.wr_data (s_q.w_data[7:0]),
		.hw_set  (set_sec),
		.flags   (flags_sec)
	); // R1

	// pending means the global flag is set and enabled
	assign pending = flags_sec[NIC_S_ANY_SOURCE] &
		s_q.en_sec[NIC_S_ANY_SOURCE]; // R4

	// read mux, bit 7 of flag registers reads zero
	always_comb begin
		rd_byte = 8'h00;
		rd_ok   = 1'b1;
		unique case (s_axi_araddr)
			NIC_OFS_FLAGS_PRI:  rd_byte = {1'b0, flags_pri};
			NIC_OFS_FLAGS_SEC:  rd_byte = {1'b0, flags_sec};
			NIC_OFS_EN_PRI:     rd_byte = s_q.en_pri;
			NIC_OFS_EN_SEC:     rd_byte = s_q.en_sec;
			NIC_OFS_STATUS_ONE: rd_byte[NIC_ST_IRQ] = pending; // R5
			NIC_OFS_PIN_CTRL:   rd_byte = {6'h00, s_q.pin_ctrl};
			NIC_OFS_EVT_STAT:   rd_byte = {5'h00, s_q.evt};
			NIC_OFS_EVT_MASK:   rd_byte = {5'h00, s_q.evt_mask};
			default:            rd_ok   = 1'b0;
		endcase
	end

	always_comb begin
		unique case (s_q.aw_addr)
			NIC_OFS_FLAGS_PRI, NIC_OFS_FLAGS_SEC,
			NIC_OFS_EN_PRI, NIC_OFS_EN_SEC,
			NIC_OFS_STATUS_ONE, NIC_OFS_PIN_CTRL,
			NIC_OFS_EVT_STAT, NIC_OFS_EVT_MASK: wr_ok = 1'b1;
			default:                            wr_ok = 1'b0;
		endcase
	end

	// bus event status: set by hardware, cleared by reading it
	always_comb begin
		evt_new = '0;
		evt_new[NIC_EV_BAD_WR]  = commit & ~wr_ok;
		evt_new[NIC_EV_BAD_RD]  = rd_take & ~rd_ok;
		evt_new[NIC_EV_PENDING] = pending & ~s_q.pending_q;
		evt_clr = '0;
		if (rd_take && s_axi_araddr == NIC_OFS_EVT_STAT) begin
			evt_clr = '1;
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.tx_eof_q   = tx_eof_pattern;
		s_d.cmd_busy_q = cmd_busy;
		s_d.pending_q  = pending;

		// write address and data may come in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end

		if (commit) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = wr_ok ? NIC_RESP_OKAY : NIC_RESP_SLVERR;
			if (s_q.w_strb[0]) begin
				unique case (s_q.aw_addr)
					NIC_OFS_EN_PRI:
						s_d.en_pri = s_q.w_data[7:0]; // R4
					NIC_OFS_EN_SEC:
						s_d.en_sec = s_q.w_data[7:0]; // R4
					NIC_OFS_PIN_CTRL:
						s_d.pin_ctrl = s_q.w_data[1:0]; // R5
					NIC_OFS_EVT_MASK:
						s_d.evt_mask = s_q.w_data[NIC_EV_W-1:0];
					default: ;
				endcase
			end
		end else if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		if (rd_take) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = {24'h000000, rd_byte};
			s_d.rresp  = rd_ok ? NIC_RESP_OKAY : NIC_RESP_SLVERR;
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// set wins over the read clear
		s_d.evt = (s_q.evt & ~evt_clr) | evt_new;

		// pending drives the pin only when activated, masked bus events always; polarity selectable
		s_d.irq = ((pending & s_q.pin_ctrl[NIC_PC_ENABLE]) | // R5
			|(s_d.evt & s_q.evt_mask)) ^
			s_q.pin_ctrl[NIC_PC_ACT_LOW];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q.aw_have    <= 1'b0;
			s_q.aw_addr    <= '0;
			s_q.w_have     <= 1'b0;
			s_q.w_data     <= '0;
			s_q.w_strb     <= 4'h0;
			s_q.bvalid     <= 1'b0;
			s_q.bresp      <= NIC_RESP_OKAY;
			s_q.rvalid     <= 1'b0;
			s_q.rdata      <= '0;
			s_q.rresp      <= NIC_RESP_OKAY;
			s_q.en_pri     <= NIC_EN_RST;
			s_q.en_sec     <= NIC_EN_RST;
			s_q.pin_ctrl   <= NIC_PIN_CTRL_RST;
			s_q.evt        <= '0;
			s_q.evt_mask   <= NIC_EVT_MASK_RST;
			s_q.tx_eof_q   <= 1'b0;
			s_q.cmd_busy_q <= 1'b0;
			s_q.pending_q  <= 1'b0;
			s_q.irq        <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = ~s_q.aw_have & ~s_q.bvalid;
	assign s_axi_wready  = ~s_q.w_have & ~s_q.bvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = ~s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign irq_req       = s_q.irq;

endmodule // nic_irq_ctrl

`default_nettype wire

// ---- sim/nic_host_mdl.sv ----
// Purpose: host side of the interrupt pin
// Assumes: pin sampled on aclk
// Notes:   irq_seen lags irq_req by one cycle
`default_nettype none

module nic_host_mdl (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic irq_req,
	output var  logic irq_seen
);
	timeunit 1ns;
	timeprecision 1ps;

	// host latches the request line
	always_ff @(posedge aclk) begin
		irq_seen <= aresetn ? irq_req : 1'b0;
	end
endmodule // nic_host_mdl

`default_nettype wire

// ---- sim/nic_irq_ctrl_chk.sv ----
// Purpose: port checks of the interrupt controller
// Assumes: single aclk domain
// Notes:   bound into every controller instance
`default_nettype none

module nic_irq_ctrl_chk
	import nic_pkg::*;
(
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [NIC_ADDR_W-1:0] s_axi_araddr,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [NIC_DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]            s_axi_rresp,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic                  irq_req
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("read taken while answer pending");
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_block: assert property (p_aw_block)
		else $error("write taken while response pending");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer late");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write response late");
	property p_rd_pad;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rd_pad: assert property (p_rd_pad)
		else $error("read data wider than eight bits");
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c
			|=> s_axi_rresp == NIC_RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not refused");
	property p_irq_rst;
		$rose(aresetn) |-> !irq_req;
	endproperty
	a_irq_rst: assert property (p_irq_rst)
		else $error("interrupt pin active out of reset");
endmodule // nic_irq_ctrl_chk

bind nic_irq_ctrl nic_irq_ctrl_chk i_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .irq_req(irq_req)
);

`default_nettype wire

// ---- sim/tb_nic_irq_ctrl.sv ----
// Purpose: register level bench of the interrupt controller
// Assumes: one write and one read at a time
// Notes:   ready and answers sampled at the falling edge
`default_nettype none

module tb_nic_irq_ctrl
	import nic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready, irq_req, irq_seen;
	logic [7:0]  awaddr, araddr, ops[5], exps[5];
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [11:0] src;
	logic [7:0]  uerr;
	int          err_total, num_checks;

	nic_irq_ctrl i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tx_eof_pattern(src[0]), .rx_end(src[1]),
		.cmd_busy(src[2]), .fifo_hi_alert(src[3]), .fifo_lo_alert(src[4]),
		.uart_error(uerr | {3'h0, src[5], 4'h0}), .rx_sof(src[6]),
		.timer_underflow(src[10:7]), .card_detected(src[11]),
		.irq_req(irq_req));
	nic_host_mdl i_host (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
		.irq_seen(irq_seen));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, d, input logic [1:0] er = 2'h0);
		logic aw_d, w_d, b_d, awr, wrd, bv;
		logic [1:0] rs;
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_d = 0;
		w_d = 0;
		b_d = 0;
		n = 0;
		while (!b_d && n < 100) begin
			@(negedge aclk);
			awr = awready && !aw_d;
			wrd = wready && !w_d;
			bv = bvalid;
			rs = bresp;
			@(posedge aclk);
			n++;
			if (awr) begin
				aw_d = 1;
				awvalid <= 1'b0;
			end
			if (wrd) begin
				w_d = 1;
				wvalid <= 1'b0;
			end
			if (bv) begin
				b_d = 1;
				bready <= 1'b0;
			end
		end
		if (!b_d) begin
			chk("bvalid", 32'h1, 32'h0);
			end_of_test();
		end
		chk($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, rs});
	endtask

	task automatic rd(input logic [7:0] a, e, input logic [1:0] er = 2'h0);
		logic ar_d, r_d, arr, rv;
		logic [31:0] dt;
		logic [1:0] rs;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ar_d = 0;
		r_d = 0;
		n = 0;
		while (!r_d && n < 100) begin
			@(negedge aclk);
			arr = arready && !ar_d;
			rv = rvalid;
			dt = rdata;
			rs = rresp;
			@(posedge aclk);
			n++;
			if (arr) begin
				ar_d = 1;
				arvalid <= 1'b0;
			end
			if (rv) begin
				r_d = 1;
				rready <= 1'b0;
			end
		end
		if (!r_d) begin
			chk("rvalid", 32'h1, 32'h0);
			end_of_test();
		end
		chk($sformatf("rdata@%h", a), {24'h0, e}, dt);
		chk($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, rs});
	endtask

	task automatic pin(input logic e);
		repeat (3) @(posedge aclk);
		// look between edges, where the pin has settled
		@(negedge aclk);
		chk("irq_req", {31'h0, e}, {31'h0, irq_req});
		chk("irq_seen", {31'h0, e}, {31'h0, irq_seen});
	endtask

	initial begin
		aresetn = 0;
		awvalid = 0;
		wvalid = 0;
		bready = 0;
		arvalid = 0;
		rready = 0;
		awaddr = 0;
		araddr = 0;
		wdata = 0;
		wstrb = 0;
		src = 0;
		uerr = 0;
		err_total = 0;
		num_checks = 0;
		ops = '{8'hff, 8'h05, 8'h00, 8'h80, 8'h7f};
		exps = '{8'h7f, 8'h7a, 8'h7a, 8'h7a, 8'h00};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 8; a++) rd(8'(a * 4), 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 5; i++) begin
			wr(NIC_OFS_FLAGS_PRI, ops[i]);
			rd(NIC_OFS_FLAGS_PRI, exps[i]);
		end
		wr(NIC_OFS_FLAGS_SEC, 8'hbf);
		rd(NIC_OFS_FLAGS_SEC, 8'h3f);
		wr(NIC_OFS_FLAGS_SEC, 8'h3f);
		rd(NIC_OFS_FLAGS_SEC, 8'h00);
		wr(NIC_OFS_EN_PRI, 8'ha5);
		rd(NIC_OFS_EN_PRI, 8'ha5);
		wr(NIC_OFS_EN_SEC, 8'h5a);
		rd(NIC_OFS_EN_SEC, 8'h5a);
		wr(NIC_OFS_EN_PRI, 8'h00);
		wr(NIC_OFS_EN_SEC, 8'h00);
		$display("test set clear done");
		for (int i = 0; i < 12; i++) begin
			@(posedge aclk) src <= 12'(1 << i);
			repeat (3) @(posedge aclk);
			src <= 12'h0;
			repeat (3) @(posedge aclk);
			rd(i < 7 ? NIC_OFS_FLAGS_PRI : NIC_OFS_FLAGS_SEC,
				8'(1 << (i < 7 ? i : i - 7)));
			wr(i < 7 ? NIC_OFS_FLAGS_PRI : NIC_OFS_FLAGS_SEC, 8'h7f);
		end
		// every receive error bit alone must raise the error flag
		for (int j = 0; j < 8; j++) begin
			@(posedge aclk) uerr <= 8'(1 << j);
			@(posedge aclk) uerr <= 8'h00;
			repeat (3) @(posedge aclk);
			rd(NIC_OFS_FLAGS_PRI, 8'(1 << NIC_P_RX_ERR));
			wr(NIC_OFS_FLAGS_PRI, 8'(1 << NIC_P_RX_ERR));
		end
		// a steady end-of-frame level must not set the flag again
		@(posedge aclk) src <= 12'h001;
		repeat (3) @(posedge aclk);
		wr(NIC_OFS_FLAGS_PRI, 8'h01);
		rd(NIC_OFS_FLAGS_PRI, 8'h00);
		@(posedge aclk) src <= 12'h000;
		$display("test sources done");
		wr(8'h20, 8'h01, NIC_RESP_SLVERR);
		rd(8'h20, 8'h00, NIC_RESP_SLVERR);
		rd(NIC_OFS_EVT_STAT, 8'h03);
		rd(NIC_OFS_EVT_STAT, 8'h00);
		wr(NIC_OFS_EVT_MASK, 8'h01);
		wr(8'h24, 8'h01, NIC_RESP_SLVERR);
		pin(1'b1);
		rd(NIC_OFS_EVT_STAT, 8'h01);
		pin(1'b0);
		wr(NIC_OFS_EVT_MASK, 8'h00);
		$display("test bus events done");
		wr(NIC_OFS_FLAGS_PRI, 8'h81);
		wr(NIC_OFS_EN_SEC, 8'h40);
		repeat (3) @(posedge aclk);
		rd(NIC_OFS_FLAGS_SEC, 8'h00);
		rd(NIC_OFS_STATUS_ONE, 8'h00);
		wr(NIC_OFS_EN_PRI, 8'h01);
		repeat (3) @(posedge aclk);
		rd(NIC_OFS_FLAGS_SEC, 8'h40);
		rd(NIC_OFS_STATUS_ONE, 8'h01);
		pin(1'b0);
		wr(NIC_OFS_PIN_CTRL, 8'h01);
		pin(1'b1);
		wr(NIC_OFS_PIN_CTRL, 8'h03);
		pin(1'b0);
		wr(NIC_OFS_PIN_CTRL, 8'h01);
		wr(NIC_OFS_EN_PRI, 8'h00);
		wr(NIC_OFS_FLAGS_PRI, 8'h01);
		wr(NIC_OFS_FLAGS_SEC, 8'h40);
		repeat (3) @(posedge aclk);
		rd(NIC_OFS_FLAGS_SEC, 8'h00);
		rd(NIC_OFS_STATUS_ONE, 8'h00);
		pin(1'b0);
		$display("test pending done");
		end_of_test();
	end
endmodule // tb_nic_irq_ctrl

`default_nettype wire
